// *** lsio_pkg.sv ***
// Purpose: Shared constants for the LCD-shared I/O ports block
// Assumes: AXI4-Lite with 16-bit byte addresses, 32-bit data
// Notes: Offsets are byte addresses of aligned words
`default_nettype none

package lsio_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] LSIO_P9_LATCH_OFS = 16'hFFDC; // Port nine data
  localparam logic [15:0] LSIO_P9_DIR_OFS = 16'hFFEC; // Port nine direction
  localparam logic [15:0] LSIO_P8_LATCH_OFS = 16'hFFE0; // Port eight data
  localparam logic [15:0] LSIO_P8_DIR_OFS = 16'hFFF0; // Port eight direction
  localparam logic [15:0] LSIO_LCD_PORT_CONTROL_REG_OFS = 16'hFFF4; // LCD port control

  // ****************************************
  // Reset values and fields
  // ****************************************
  localparam logic [7:0] LSIO_LATCH_RST = 8'h00; // Output latches
  localparam logic [7:0] LSIO_DIR_RST = 8'h00; // All pins inputs
  localparam logic [4:0] LSIO_LCD_PORT_CONTROL_REG_RST = 5'h00; // All pins general I/O
  localparam logic [7:0] LSIO_WO_READ = 8'hFF; // Write-only reads as ones
  localparam int LSIO_SGX_BIT = 4; // Controller-signal select bit
  localparam logic [1:0] LSIO_RESP_OKAY = 2'h0; // AXI okay
  localparam logic [1:0] LSIO_RESP_SLVERR = 2'h2; // AXI slave error

  // ****************************************
  // Operating modes of the chip
  // ****************************************
  typedef enum logic [2:0]
  {
    LSIO_ACTIVE = 3'h0,
    LSIO_SUBACTIVE = 3'h1,
    LSIO_SLEEP = 3'h2,
    LSIO_SUBSLEEP = 3'h3,
    LSIO_WATCH = 3'h4,
    LSIO_STANDBY = 3'h5
  } lsio_mode_t;

endpackage // lsio_pkg

`default_nettype wire

// *** lsio_ports.sv ***
// Purpose: Two 8-bit general I/O ports shared with LCD segment and control outputs
// Assumes: Pin inputs and mode input synchronous to aclk
// Notes: Registers reached over AXI4-Lite; pins are split in/out/enable
`default_nettype none

module lsio_ports
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Chip operating mode
  input wire lsio_pkg::lsio_mode_t op_mode,
  // LCD controller side
  input wire logic [15:0] lcd_drive_line,
  input wire logic lcd_first_latch_clock,
  input wire logic lcd_second_latch_clock,
  input wire logic lcd_serial_data,
  input wire logic lcd_alt_signal,
  // Port eight pins
  input wire logic [7:0] p8_in,
  output logic [7:0] p8_out,
  output logic [7:0] p8_oe,
  // Port nine pins
  input wire logic [7:0] p9_in,
  output logic [7:0] p9_out,
  output logic [7:0] p9_oe
);
  import lsio_pkg::*;

  // ****************************************
  // Pin function decode
  // ****************************************
  // True when pin idx of the port is general I/O
  function automatic logic pin_is_gpio(input logic port9, input int idx,
                                       input logic [4:0] lcd_port_control_reg);
    logic [3:0] sgs;
    sgs = lcd_port_control_reg[3:0];
    if (port9)
    begin
      // Control signals override on the upper pins
      pin_is_gpio = (sgs == 4'h0) && !(idx >= 4 && lcd_port_control_reg[LSIO_SGX_BIT]);
    end
    else if (idx >= 4)
    begin
      pin_is_gpio = (sgs[3:1] == 3'h0);
    end
    else
    begin
      pin_is_gpio = (sgs[3:1] == 3'h0) || (sgs == 4'h2);
    end
  endfunction

  // Data register readback mixes latch and pin by direction
  function automatic logic [7:0] port_read(input logic [7:0] dir,
                                           input logic [7:0] latch,
                                           input logic [7:0] pins);
    port_read = (dir & latch) | (~dir & pins);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [7:0] l8_r, l8_nxt; // Port eight output latch
  logic [7:0] d8_r, d8_nxt; // Port eight direction
  logic [7:0] l9_r, l9_nxt; // Port nine output latch
  logic [7:0] d9_r, d9_nxt; // Port nine direction
  logic [4:0] lcd_port_control_reg_r, lcd_port_control_reg_nxt; // Segment field and control select
  logic aw_hold_r, aw_hold_nxt; // Write address captured
  logic [15:0] aw_addr_r, aw_addr_nxt;
  logic w_hold_r, w_hold_nxt; // Write data captured
  logic [31:0] w_data_r, w_data_nxt;
  logic w_lane0_r, w_lane0_nxt; // Low byte strobe
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] ar_addr_r, ar_addr_nxt; // Last read address
  logic [7:0] p8_out_r, p8_out_nxt;
  logic [7:0] p8_oe_r, p8_oe_nxt;
  logic [7:0] p9_out_r, p9_out_nxt;
  logic [7:0] p9_oe_r, p9_oe_nxt;
  logic [7:0] p8_fo, p8_fe, p9_fo, p9_fe; // Functional pin drive
  logic do_write; // Both halves of a write present
  logic hold_mode; // Pins frozen in sleep, subsleep and watch modes

  // ****************************************
  // Bus and register next state
  // ****************************************
  // Address and data are taken in any order; the write commits once both are held
  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt = w_hold_r;
    w_data_nxt = w_data_r;
    w_lane0_nxt = w_lane0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ar_addr_nxt = ar_addr_r;
    l8_nxt = l8_r;
    d8_nxt = d8_r;
    l9_nxt = l9_r;
    d9_nxt = d9_r;
    lcd_port_control_reg_nxt = lcd_port_control_reg_r;
    do_write = aw_hold_r && w_hold_r && !bvalid_r;
    // Capture address
    if (s_axi_awvalid && awready_r)
    begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    // Capture data
    if (s_axi_wvalid && wready_r)
    begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_lane0_nxt = s_axi_wstrb[0];
    end
    // Response accepted by master
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    // Commit; only the low byte lane carries register bits
    if (do_write)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = LSIO_RESP_OKAY;
      case ({aw_addr_r[15:2], 2'h0})
        LSIO_P9_LATCH_OFS: if (w_lane0_r) l9_nxt = w_data_r[7:0];
        LSIO_P9_DIR_OFS: if (w_lane0_r) d9_nxt = w_data_r[7:0];
        LSIO_P8_LATCH_OFS: if (w_lane0_r) l8_nxt = w_data_r[7:0];
        LSIO_P8_DIR_OFS: if (w_lane0_r) d8_nxt = w_data_r[7:0];
        LSIO_LCD_PORT_CONTROL_REG_OFS: if (w_lane0_r) lcd_port_control_reg_nxt = w_data_r[4:0];
        default: bresp_nxt = LSIO_RESP_SLVERR; // Unmapped address
      endcase
    end
    // Read data returned after address taken
    if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = LSIO_RESP_OKAY;
      ar_addr_nxt = s_axi_araddr;
      rdata_nxt = 32'h0000_0000;
      case ({s_axi_araddr[15:2], 2'h0})
        LSIO_P9_LATCH_OFS: rdata_nxt[7:0] = port_read(d9_r, l9_r, p9_in);
        LSIO_P9_DIR_OFS: rdata_nxt[7:0] = LSIO_WO_READ;
        LSIO_P8_LATCH_OFS: rdata_nxt[7:0] = port_read(d8_r, l8_r, p8_in);
        LSIO_P8_DIR_OFS: rdata_nxt[7:0] = LSIO_WO_READ;
        LSIO_LCD_PORT_CONTROL_REG_OFS: rdata_nxt[4:0] = lcd_port_control_reg_r;
        default: rresp_nxt = LSIO_RESP_SLVERR;
      endcase
    end
    // One write and one read in flight at a time
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt = !w_hold_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  // ****************************************
  // Pin function multiplexers
  // ****************************************
  // Segment or controller pins ignore latch and direction
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      always_comb
      begin
        if (pin_is_gpio(1'b0, gi, lcd_port_control_reg_r))
        begin
          p8_fo[gi] = l8_r[gi];
          p8_fe[gi] = d8_r[gi];
        end
        else
        begin
          p8_fo[gi] = lcd_drive_line[gi];
          p8_fe[gi] = 1'b1;
        end
        if (pin_is_gpio(1'b1, gi, lcd_port_control_reg_r))
        begin
          p9_fo[gi] = l9_r[gi];
          p9_fe[gi] = d9_r[gi];
        end
        else if (gi >= 4 && lcd_port_control_reg_r[LSIO_SGX_BIT])
        begin
          // Pins 7..4 carry first clock, second clock, data, alternation
          case (gi)
            7: p9_fo[gi] = lcd_first_latch_clock;
            6: p9_fo[gi] = lcd_second_latch_clock;
            5: p9_fo[gi] = lcd_serial_data;
            default: p9_fo[gi] = lcd_alt_signal;
          endcase
          p9_fe[gi] = 1'b1;
        end
        else
        begin
          p9_fo[gi] = lcd_drive_line[gi + 8];
          p9_fe[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // ****************************************
  // Low-power pin state
  // ****************************************
  // Sleeping modes freeze the pins so the LCD glass keeps its pattern
  always_comb
  begin
    hold_mode = (op_mode == LSIO_SLEEP) || (op_mode == LSIO_SUBSLEEP)
                || (op_mode == LSIO_WATCH);
    p8_out_nxt = p8_fo;
    p8_oe_nxt = p8_fe;
    p9_out_nxt = p9_fo;
    p9_oe_nxt = p9_fe;
    if (op_mode == LSIO_STANDBY)
    begin
      p8_oe_nxt = 8'h00;
      p9_oe_nxt = 8'h00;
    end
    else if (hold_mode)
    begin
      p8_out_nxt = p8_out_r;
      p8_oe_nxt = p8_oe_r;
      p9_out_nxt = p9_out_r;
      p9_oe_nxt = p9_oe_r;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset floats every pin and clears latches and directions
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      l8_r <= LSIO_LATCH_RST;
      d8_r <= LSIO_DIR_RST;
      l9_r <= LSIO_LATCH_RST;
      d9_r <= LSIO_DIR_RST;
      lcd_port_control_reg_r <= LSIO_LCD_PORT_CONTROL_REG_RST;
      aw_hold_r <= 1'b0;
      aw_addr_r <= 16'h0000;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_lane0_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= LSIO_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= LSIO_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      ar_addr_r <= 16'h0000;
      p8_out_r <= 8'h00;
      p8_oe_r <= 8'h00;
      p9_out_r <= 8'h00;
      p9_oe_r <= 8'h00;
    end
    else
    begin
      l8_r <= l8_nxt;
      d8_r <= d8_nxt;
      l9_r <= l9_nxt;
      d9_r <= d9_nxt;
      lcd_port_control_reg_r <= lcd_port_control_reg_nxt;
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      w_lane0_r <= w_lane0_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ar_addr_r <= ar_addr_nxt;
      p8_out_r <= p8_out_nxt;
      p8_oe_r <= p8_oe_nxt;
      p9_out_r <= p9_out_nxt;
      p9_oe_r <= p9_oe_nxt;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign p8_out = p8_out_r;
  assign p8_oe = p8_oe_r;
  assign p9_out = p9_out_r;
  assign p9_oe = p9_oe_r;

  // ****************************************
  // Assertions
  // ****************************************
  a_reset_clears: assert property (@(posedge aclk)
    !aresetn |=> (l9_r == 8'h00) && (d9_r == 8'h00) && (p9_oe_r == 8'h00))
    else $error("Port nine not cleared by reset");
  a_dir9_ones: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(rvalid_r) && ({ar_addr_r[15:2], 2'h0} == 16'hFFEC) |-> rdata_r == 32'h0000_00FF)
    else $error("Direction read not all ones");
  a_data9_mix: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(rvalid_r) && ({ar_addr_r[15:2], 2'h0} == 16'hFFDC)
    |-> rdata_r[7:0] == (($past(d9_r) & $past(l9_r)) | (~$past(d9_r) & $past(p9_in))))
    else $error("Data read mix wrong");
  a_standby_float: assert property (@(posedge aclk) disable iff (!aresetn)
    op_mode == LSIO_STANDBY |=> (p8_oe_r == 8'h00) && (p9_oe_r == 8'h00))
    else $error("Pins driven in standby");
  a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    hold_mode |=> $stable(p8_out_r) && $stable(p8_oe_r) && $stable(p9_out_r))
    else $error("Pins changed while held");
  a_gpio9_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    op_mode == LSIO_ACTIVE && lcd_port_control_reg_r == 5'h00
    |=> p9_out_r == $past(l9_r) && p9_oe_r == $past(d9_r))
    else $error("General pin drive wrong");
  a_ctrl_pins: assert property (@(posedge aclk) disable iff (!aresetn)
    op_mode == LSIO_ACTIVE && lcd_port_control_reg_r[4]
    |=> p9_oe_r[7:4] == 4'hF && p9_out_r[7] == $past(lcd_first_latch_clock))
    else $error("Controller pins wrong");
  a_seg8_split: assert property (@(posedge aclk) disable iff (!aresetn)
    op_mode == LSIO_ACTIVE && lcd_port_control_reg_r[3:0] == 4'h2
    |=> p8_oe_r[7:4] == 4'hF && p8_oe_r[3:0] == $past(d8_r[3:0]))
    else $error("Port eight split wrong");
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid ##0 (s_axi_bvalid && !s_axi_bready) [*1] |=> s_axi_bvalid)
    else $error("Write response dropped");

endmodule // lsio_ports

`default_nettype wire

// *** lsio_far_model.sv ***
// Purpose: Far side of the shared ports: outside pin drivers and the LCD controller
// Assumes: Bench sets the outside levels and the LCD pattern after a clock edge
// Notes: Where the block drives a pin, the pin shows the block's value
`default_nettype none

module lsio_far_model
(
  // Outside levels and LCD pattern from the bench
  input wire logic [7:0] ext8,
  input wire logic [7:0] ext9,
  input wire logic [19:0] lcd_pat,
  // Pin side of the block
  input wire logic [7:0] p8_out,
  input wire logic [7:0] p8_oe,
  input wire logic [7:0] p9_out,
  input wire logic [7:0] p9_oe,
  output logic [7:0] p8_in,
  output logic [7:0] p9_in,
  // LCD controller outputs
  output logic [15:0] lcd_drive_line,
  output logic lcd_first_latch_clock,
  output logic lcd_second_latch_clock,
  output logic lcd_serial_data,
  output logic lcd_alt_signal
);
  timeunit 1ns;
  timeprecision 1ns;

  // Wire level: the block wins where enabled, the outside drives the rest
  assign p8_in = (p8_oe & p8_out) | (~p8_oe & ext8);
  assign p9_in = (p9_oe & p9_out) | (~p9_oe & ext9);

  // Controller lines; the pattern differs from any latch value the bench writes
  assign lcd_drive_line = lcd_pat[15:0];
  assign lcd_first_latch_clock = lcd_pat[19];
  assign lcd_second_latch_clock = lcd_pat[18];
  assign lcd_serial_data = lcd_pat[17];
  assign lcd_alt_signal = lcd_pat[16];
endmodule // lsio_far_model

`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the LCD-shared I/O ports
// Assumes: AXI4-Lite slave answers within a few cycles of each request
// Notes: Pin checks mask the output value where the enable is low
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lsio_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, e;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  lsio_mode_t op_mode = LSIO_ACTIVE;
  logic [15:0] lcd_drive_line;
  logic lcd_first_latch_clock, lcd_second_latch_clock, lcd_serial_data, lcd_alt_signal;
  logic [7:0] p8_in, p9_in, p8_out, p8_oe, p9_out, p9_oe, l8, d8, l9, d9, pin9, pin8;
  logic [7:0] ext8 = '0, ext9 = '0;
  logic [19:0] lcd_pat = '0;
  int failures = 0, compares = 0, seed = 24, cycles = 0;

  // ****************************************
  // Design and far side
  // ****************************************
  lsio_ports i_lsio_ports (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_mode, .lcd_drive_line,
    .lcd_first_latch_clock, .lcd_second_latch_clock, .lcd_serial_data, .lcd_alt_signal,
    .p8_in, .p8_out, .p8_oe, .p9_in, .p9_out, .p9_oe);
  lsio_far_model i_lsio_far_model (.ext8, .ext9, .lcd_pat, .p8_out, .p8_oe, .p9_out,
    .p9_oe, .p8_in, .p9_in, .lcd_drive_line, .lcd_first_latch_clock,
    .lcd_second_latch_clock, .lcd_serial_data, .lcd_alt_signal);

  // Clock at 10 MHz, and a ceiling well above the expected run length
  always #50 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      failures++;
      conclude();
    end
  end

  // ****************************************
  // Checks and closing report
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chk_resp(input string nm, input logic [1:0] ex, input logic [1:0] got);
    compares++;
    if (got !== ex)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Expected {p9_oe, p9_out masked, p8_oe, p8_out masked} for one select setting
  function automatic logic [31:0] exp_pins(input logic [4:0] c, input logic [7:0] l8,
    input logic [7:0] d8, input logic [7:0] l9, input logic [7:0] d9, input logic [19:0] p);
    logic [7:0] g8, g9, o8, o9, v8, v9;
    g8 = {{4{c[3:1] == 3'h0}}, {4{c[3:1] == 3'h0 || c[3:0] == 4'h2}}};
    g9 = {{4{c[3:0] == 4'h0 && !c[4]}}, {4{c[3:0] == 4'h0}}};
    o8 = (g8 & d8) | ~g8;
    o9 = (g9 & d9) | ~g9;
    v8 = (g8 & l8) | (~g8 & p[7:0]);
    v9 = (g9 & l9) | (~g9 & {c[4] ? p[19:16] : p[15:12], p[11:8]});
    return {o9, v9 & o9, o8, v8 & o8};
  endfunction

  // ****************************************
  // Bus master tasks, entered just after a rising edge
  // ****************************************
  task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic [3:0] s,
    output logic [1:0] rs);
    bit aw = 1'b0;
    bit w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'hA5A5A5, v};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (s_axi_awready)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    // Let an edge pass so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    // Let an edge pass so a following call never re-raises rready in this step
    @(posedge aclk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge aclk);
    chk("oe in reset", 32'h0, {16'h0, p9_oe, p8_oe});
    aresetn <= 1'h1;
    ext9 <= 8'($random(seed));
    ext8 <= 8'($random(seed));
    @(posedge aclk);
    rd(LSIO_P9_DIR_OFS, d, r);
    chk("p9 dir read", 32'h000000FF, d);
    rd(LSIO_P8_DIR_OFS, d, r);
    chk("p8 dir read", 32'h000000FF, d);
    rd(LSIO_P9_LATCH_OFS, d, r);
    chk("p9 data inputs", {24'h0, ext9}, d);
    wr(LSIO_P9_DIR_OFS, 8'hFF, 4'hF, r);
    rd(LSIO_P9_LATCH_OFS, d, r);
    chk("p9 latch reset", 32'h0, d);
    wr(16'hFFF8, 8'h55, 4'hF, r);
    chk_resp("unmapped write", LSIO_RESP_SLVERR, r);
    rd(16'hFFF8, d, r);
    chk_resp("unmapped read", LSIO_RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
    wr(LSIO_P9_LATCH_OFS, 8'h5A, 4'h0, r);
    rd(LSIO_P9_LATCH_OFS, d, r);
    chk("strobe off", 32'h0, d);
    // Every select code, with random latches, directions and LCD lines
    for (int c = 0; c < 32; c++)
    begin
      {l8, d8, l9, d9} = $random(seed);
      lcd_pat <= 20'($random(seed));
      ext9 <= 8'($random(seed));
      wr(LSIO_P8_LATCH_OFS, l8, 4'hF, r);
      wr(LSIO_P8_DIR_OFS, d8, 4'hF, r);
      wr(LSIO_P9_LATCH_OFS, l9, 4'hF, r);
      wr(LSIO_P9_DIR_OFS, d9, 4'hF, r);
      wr(LSIO_LCD_PORT_CONTROL_REG_OFS, 8'(c), 4'hF, r);
      chk_resp("write resp", LSIO_RESP_OKAY, r);
      repeat (2) @(posedge aclk);
      e = exp_pins(5'(c), l8, d8, l9, d9, lcd_pat);
      chk("pins", e, {p9_oe, p9_out & p9_oe, p8_oe, p8_out & p8_oe});
      pin9 = e[23:16] | (~e[31:24] & ext9);
      rd(LSIO_P9_LATCH_OFS, d, r);
      chk("p9 data read", {24'h0, (l9 & d9) | (pin9 & ~d9)}, d);
      // Port eight readback and the select register are decoded too
      pin8 = e[7:0] | (~e[15:8] & ext8);
      rd(LSIO_P8_LATCH_OFS, d, r);
      chk("p8 data read", {24'h0, (l8 & d8) | (pin8 & ~d8)}, d);
      rd(LSIO_LCD_PORT_CONTROL_REG_OFS, d, r);
      chk("select read", {27'h0, 5'(c)}, d);
    end
    // Low-power modes: frozen, floating or functional
    wr(LSIO_LCD_PORT_CONTROL_REG_OFS, 8'h00, 4'hF, r);
    wr(LSIO_P9_DIR_OFS, 8'hFF, 4'hF, r);
    for (int i = 1; i < 6; i++)
    begin
      op_mode <= lsio_mode_t'(3'(i));
      l9 = ~l9;
      repeat (2) @(posedge aclk);
      wr(LSIO_P9_LATCH_OFS, l9, 4'hF, r);
      repeat (2) @(posedge aclk);
      if (i == 5)
        chk("standby oe", 32'h0, {16'h0, p9_oe, p8_oe});
      else
        chk("mode pins", {16'h0, 8'hFF, i == 1 ? l9 : ~l9}, {16'h0, p9_oe, p9_out});
      op_mode <= LSIO_ACTIVE;
      repeat (2) @(posedge aclk);
      chk("active pins", {16'h0, 8'hFF, l9}, {16'h0, p9_oe, p9_out});
    end
    // Second reset in mid-run
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("oe second reset", 32'h0, {16'h0, p9_oe, p8_oe});
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(LSIO_P9_LATCH_OFS, d, r);
    chk("p9 dir cleared", {24'h0, ext9}, d);
    conclude();
  end
endmodule // tb

`default_nettype wire
